// File: acp_map.svh
`ifndef ACP_MAP_SVH
`define ACP_MAP_SVH

// Control byte field positions
`define ACP_ST_BIT     0
`define ACP_CMD_LSB    1
`define ACP_RDY_BIT    3
`define ACP_MODE_LSB   4

// Command codes
`define ACP_CMD_ENC    2'h0
`define ACP_CMD_DEC    2'h1
`define ACP_CMD_LDKEY  2'h2
`define ACP_CMD_LDIV   2'h3

// Mode codes
`define ACP_MODE_CBC   3'h0
`define ACP_MODE_CFB   3'h1
`define ACP_MODE_OFB   3'h2
`define ACP_MODE_CTR   3'h3
`define ACP_MODE_ECB   3'h4
`define ACP_MODE_MAC   3'h5

// Reset values and counts
`define ACP_KEY_RST    128'h0
`define ACP_IV_RST     128'h0
`define ACP_MODE_RST   3'h0
`define ACP_CMD_RST    2'h0
`define ACP_ROUNDS     4'hA
`define ACP_BLK_LAST   4'hF
`define ACP_WORD_LAST  2'h3

`endif

// File: acp_pkg.sv
package acp_pkg;

	typedef enum logic [1:0] {ACP_OP_ENC, ACP_OP_DEC, ACP_OP_PREP} acp_op_t;

	typedef enum logic [2:0] {
		ACP_S_IDLE, ACP_S_KEY, ACP_S_IV, ACP_S_PREP,
		ACP_S_IN, ACP_S_RUN, ACP_S_KS, ACP_S_OUT
	} acp_state_t;

	// Multiply in GF(2^8) modulo x^8+x^4+x^3+x+1
	function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) begin
				p = p ^ x;
			end
			x = x[7] ? ({x[6:0], 1'b0} ^ 8'h1B) : {x[6:0], 1'b0};
		end
		return p;
	endfunction

endpackage

// File: acp_core_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acp_core_if;
	logic                go;
	logic                abort;
	acp_pkg::acp_op_t    op;
	logic [127:0]        key;
	logic [127:0]        din;
	logic [127:0]        dout;
	logic                done;

	modport ctl (output go, output abort, output op, output key, output din,
		input dout, input done);
	modport core (input go, input abort, input op, input key, input din,
		output dout, output done);
endinterface
`default_nettype wire

// File: acp_sbox.sv
`timescale 1ns/1ps
`default_nettype none
module acp_sbox (
	input  wire logic [7:0] a,
	input  wire logic       inv,
	output logic      [7:0] y
);
	// Field inverse as x^254; costs area but saves two 256-entry tables
	function automatic logic [7:0] ginv(input logic [7:0] x);
		logic [7:0] r;
		logic [7:0] p;
		r = 8'h01;
		p = x;
		for (int i = 0; i < 7; i++) begin
			p = acp_pkg::gmul(p, p);
			r = acp_pkg::gmul(r, p);
		end
		return r;
	endfunction

	function automatic logic [7:0] rol(input logic [7:0] x, input int n);
		return 8'((x << n) | (x >> (8 - n)));
	endfunction

	logic [7:0] fwd_in;
	logic [7:0] inv_pre;

	// Forward: inverse then affine; inverse: undo affine then invert
	always_comb begin
		fwd_in  = ginv(a);
		inv_pre = rol(a, 1) ^ rol(a, 3) ^ rol(a, 6) ^ 8'h05;
		if (inv) begin
			y = ginv(inv_pre);
		end else begin
			y = fwd_in ^ rol(fwd_in, 1) ^ rol(fwd_in, 2) ^ rol(fwd_in, 3) ^ rol(fwd_in, 4) ^ 8'h63;
		end
	end
endmodule
`default_nettype wire

// File: acp_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "acp_map.svh"
module acp_core (
	input  wire logic mclk,
	input  wire logic rst_n,
	acp_core_if.core  cif
);
	logic [127:0]     st;
	logic [127:0]     rk;
	logic [127:0]     klast;
	logic [3:0]       rnd;
	logic             run;
	logic             done;
	acp_pkg::acp_op_t op;
	logic [127:0]     sb_v;
	logic [31:0]      kin;
	logic [31:0]      subw;
	logic [7:0]       rc;
	logic [127:0]     nk;
	logic [127:0]     pk;
	logic [127:0]     t_dec;
	logic [127:0]     t_enc;
	logic             is_dec;

	function automatic logic [7:0] rcon(input logic [3:0] r);
		logic [7:0] c;
		c = 8'h01;
		for (int i = 2; i <= 10; i++) begin
			if (4'(i) <= r) begin
				c = acp_pkg::gmul(c, 8'h02);
			end
		end
		return c;
	endfunction

	// Column mix, forward or inverse coefficient set
	function automatic logic [31:0] mixc(input logic [31:0] c, input logic inv);
		logic [7:0] m [4];
		logic [31:0] o;
		m = inv ? '{8'h0E, 8'h0B, 8'h0D, 8'h09} : '{8'h02, 8'h03, 8'h01, 8'h01};
		o = 32'h0;
		for (int r = 0; r < 4; r++) begin
			for (int j = 0; j < 4; j++) begin
				o[(3 - r) * 8 +: 8] ^= acp_pkg::gmul(c[(3 - j) * 8 +: 8], m[(j - r + 4) % 4]);
			end
		end
		return o;
	endfunction

	function automatic logic [127:0] mix(input logic [127:0] s, input logic inv);
		logic [127:0] o;
		for (int c = 0; c < 4; c++) begin
			o[(3 - c) * 32 +: 32] = mixc(s[(3 - c) * 32 +: 32], inv);
		end
		return o;
	endfunction

	// Row rotation; byte b of the block sits at bits 127-8b
	function automatic logic [127:0] shr(input logic [127:0] s, input logic inv);
		logic [127:0] o;
		int src;
		for (int c = 0; c < 4; c++) begin
			for (int r = 0; r < 4; r++) begin
				src = inv ? (r + 4 * ((c - r + 4) % 4)) : (r + 4 * ((c + r) % 4));
				o[(15 - (r + 4 * c)) * 8 +: 8] = s[(15 - src) * 8 +: 8];
			end
		end
		return o;
	endfunction

	assign is_dec = (op == acp_pkg::ACP_OP_DEC);

	// State byte substitution
	for (genvar i = 0; i < 16; i++) begin : g_sb
		acp_sbox u_sb (.a(st[i * 8 +: 8]), .inv(is_dec), .y(sb_v[i * 8 +: 8]));
	end

	// Key word substitution; decryption walks the schedule backwards
	assign kin = is_dec ? (rk[31:0] ^ rk[63:32]) : rk[31:0];
	for (genvar i = 0; i < 4; i++) begin : g_kb
		acp_sbox u_kb (.a(kin[((i + 3) % 4) * 8 +: 8]), .inv(1'b0), .y(subw[i * 8 +: 8]));
	end

	assign rc = is_dec ? rcon(4'(`ACP_ROUNDS + 4'h1 - rnd)) : rcon(rnd);

	// Next and previous round keys
	always_comb begin
		nk[127:96] = rk[127:96] ^ subw ^ {rc, 24'h0};
		nk[95:64]  = rk[95:64] ^ nk[127:96];
		nk[63:32]  = rk[63:32] ^ nk[95:64];
		nk[31:0]   = rk[31:0] ^ nk[63:32];
		pk[127:96] = rk[127:96] ^ subw ^ {rc, 24'h0};
		pk[95:64]  = rk[95:64] ^ rk[127:96];
		pk[63:32]  = rk[63:32] ^ rk[95:64];
		pk[31:0]   = rk[31:0] ^ rk[63:32];
		t_enc      = (rnd == `ACP_ROUNDS) ? (shr(sb_v, 1'b0) ^ nk) : (mix(shr(sb_v, 1'b0), 1'b0) ^ nk);
		t_dec      = (rnd == `ACP_ROUNDS) ? (shr(sb_v, 1'b1) ^ pk) : mix(shr(sb_v, 1'b1) ^ pk, 1'b1);
	end

	// One round per clock; a load command aborts a running pass
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st    <= 128'h0;
			rk    <= 128'h0;
			klast <= `ACP_KEY_RST;
			rnd   <= 4'h0;
			run   <= 1'b0;
			done  <= 1'b0;
			op    <= acp_pkg::ACP_OP_ENC;
		end else begin
			done <= 1'b0;
			if (cif.abort) begin
				run <= 1'b0;
			end else if (cif.go && !run) begin
				run <= 1'b1;
				rnd <= 4'h1;
				op  <= cif.op;
				rk  <= (cif.op == acp_pkg::ACP_OP_DEC) ? klast : cif.key;
				st  <= cif.din ^ ((cif.op == acp_pkg::ACP_OP_DEC) ? klast : cif.key);
			end else if (run) begin
				rnd <= 4'(rnd + 4'h1);
				rk  <= is_dec ? pk : nk;
				st  <= is_dec ? t_dec : t_enc;
				if (rnd == `ACP_ROUNDS) begin
					run  <= 1'b0;
					done <= 1'b1;
					if (op == acp_pkg::ACP_OP_PREP) begin
						klast <= nk;
					end
				end
			end
		end
	end

	assign cif.dout = st;
	assign cif.done = done;
endmodule
`default_nettype wire

// File: acp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "acp_map.svh"
// What this block does
// - Six chaining modes with a 128-bit key and 128-bit IV.
// - Block is loaded, transformed and read out before the next may start.
// - Key or IV load aborts any block in progress.
// - Loaded key stays in use until the next key load.
// - Reset clears key and IV to zero.
// - Control/status port for the CPU, input and output data ports for DMA.
// - Start command raises the DMA trigger for the block.
// - Interrupt pulse when each block is complete.
// - Stream modes move each block as four 32-bit words, word in, word out.
// - DMA triggers pace the stream-mode words without the CPU.
// - CCM is CBC-MAC then CTR; software formats, hardware does blocks.
// - One request line for input data, one for output data.
module acp_top (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       ctrl_wr,
	input  wire logic [7:0] ctrl_wdata,
	output logic      [7:0] cipher_ctrl_status_reg,
	input  wire logic       din_wr,
	input  wire logic [7:0] cipher_input_reg,
	input  wire logic       dout_rd,
	output logic      [7:0] cipher_output_reg,
	output logic            input_dma_request,
	output logic            output_dma_request,
	output logic            block_done_irq
);
	acp_core_if cif ();

	acp_core u_core (
		.mclk  (mclk),
		.rst_n (rst_n),
		.cif   (cif)
	);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	acp_pkg::acp_state_t state;
	acp_pkg::acp_state_t next_state;
	logic [1:0]          cmd;
	logic [2:0]          mode;
	logic [127:0]        key;
	logic [127:0]        iv;
	logic [127:0]        ks;
	logic [7:0]          in_arr [16];
	logic [7:0]          out_arr [16];
	logic [3:0]          icnt;
	logic [3:0]          ocnt;
	logic                go;
	logic                abort;
	logic [1:0]          wf_cmd;
	logic [2:0]          wf_mode;
	logic                start;
	logic                ld_cmd;
	logic                run_cmd;
	logic                stream;
	logic                chain;
	logic                decrypt;
	logic                accepting;
	logic                wr_ok;
	logic                rd_ok;
	logic                chunk_in;
	logic                chunk_out;
	logic                blk_end;
	logic [127:0]        in_blk;
	logic [127:0]        out_blk;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [7:0] byte_of(input logic [127:0] v, input logic [3:0] i);
		return v[{4'hF - i, 3'h0} +: 8];
	endfunction

	function automatic logic [127:0] pack(input logic [7:0] a [16]);
		logic [127:0] p;
		for (int i = 0; i < 16; i++) begin
			p[{4'hF - 4'(i), 3'h0} +: 8] = a[i];
		end
		return p;
	endfunction

	function automatic logic is_stream(input logic [2:0] m);
		return (m == `ACP_MODE_CFB) || (m == `ACP_MODE_OFB) || (m == `ACP_MODE_CTR);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Command decode

	// Fields of the written control byte
	assign wf_cmd  = ctrl_wdata[`ACP_CMD_LSB +: 2];
	assign wf_mode = ctrl_wdata[`ACP_MODE_LSB +: 3];
	assign start   = ctrl_wr & ctrl_wdata[`ACP_ST_BIT];

	// Load commands always win, even mid-block
	assign ld_cmd  = start & ((wf_cmd == `ACP_CMD_LDKEY) | (wf_cmd == `ACP_CMD_LDIV));

	// Run commands only from idle, so a new run never overwrites an unread result
	assign run_cmd = start & ~ld_cmd & (state == acp_pkg::ACP_S_IDLE);

	assign stream  = is_stream(mode);
	assign chain   = (mode == `ACP_MODE_CBC) | (mode == `ACP_MODE_MAC);
	assign decrypt = (cmd == `ACP_CMD_DEC);

	// Data port handshakes
	assign accepting = (state == acp_pkg::ACP_S_KEY) | (state == acp_pkg::ACP_S_IV)
		| (state == acp_pkg::ACP_S_IN);
	assign wr_ok     = din_wr & accepting;
	assign rd_ok     = dout_rd & output_dma_request & (state == acp_pkg::ACP_S_OUT);

	// A chunk is a 32-bit word in stream modes, else the whole block
	assign chunk_in  = stream ? (icnt[1:0] == `ACP_WORD_LAST) : (icnt == `ACP_BLK_LAST);
	assign chunk_out = stream ? (ocnt[1:0] == `ACP_WORD_LAST) : (ocnt == `ACP_BLK_LAST);
	assign blk_end   = rd_ok & (ocnt == `ACP_BLK_LAST);

	assign in_blk  = pack(in_arr);
	assign out_blk = pack(out_arr);

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_comb begin
		next_state = state;
		if (ld_cmd) begin
			next_state = (wf_cmd == `ACP_CMD_LDKEY) ? acp_pkg::ACP_S_KEY : acp_pkg::ACP_S_IV;
		end else begin
			unique case (state)
				acp_pkg::ACP_S_IDLE: begin
					if (run_cmd) begin
						next_state = is_stream(wf_mode) ? acp_pkg::ACP_S_KS : acp_pkg::ACP_S_IN;
					end
				end
				acp_pkg::ACP_S_KEY: begin
					if (wr_ok && icnt == `ACP_BLK_LAST) begin
						next_state = acp_pkg::ACP_S_PREP;
					end
				end
				acp_pkg::ACP_S_IV: begin
					if (wr_ok && icnt == `ACP_BLK_LAST) begin
						next_state = acp_pkg::ACP_S_IDLE;
					end
				end
				acp_pkg::ACP_S_PREP: begin
					if (cif.done) begin
						next_state = acp_pkg::ACP_S_IDLE;
					end
				end
				acp_pkg::ACP_S_KS: begin
					if (cif.done) begin
						next_state = acp_pkg::ACP_S_IN;
					end
				end
				acp_pkg::ACP_S_IN: begin
					if (wr_ok && chunk_in) begin
						next_state = stream ? acp_pkg::ACP_S_OUT : acp_pkg::ACP_S_RUN;
					end
				end
				acp_pkg::ACP_S_RUN: begin
					if (cif.done) begin
						next_state = acp_pkg::ACP_S_OUT;
					end
				end
				acp_pkg::ACP_S_OUT: begin
					if (rd_ok && chunk_out) begin
						next_state = blk_end ? acp_pkg::ACP_S_IDLE : acp_pkg::ACP_S_IN;
					end
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= acp_pkg::ACP_S_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Command and mode latch; mode follows every accepted start
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmd  <= `ACP_CMD_RST;
			mode <= `ACP_MODE_RST;
		end else if (ld_cmd || run_cmd) begin
			cmd  <= wf_cmd;
			mode <= wf_mode;
		end
	end

	// Byte counters restart with each accepted command
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			icnt <= 4'h0;
			ocnt <= 4'h0;
		end else if (ld_cmd || run_cmd) begin
			icnt <= 4'h0;
			ocnt <= 4'h0;
		end else begin
			if (wr_ok) begin
				icnt <= 4'(icnt + 4'h1);
			end
			if (rd_ok) begin
				ocnt <= 4'(ocnt + 4'h1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Key and chaining value

	// Key is shifted in byte by byte and held until reloaded
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			key <= `ACP_KEY_RST;
		end else if (wr_ok && state == acp_pkg::ACP_S_KEY) begin
			key <= {key[119:0], cipher_input_reg};
		end
	end

	// IV load, then per-block chaining updates
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			iv <= `ACP_IV_RST;
		end else if (wr_ok && state == acp_pkg::ACP_S_IV) begin
			iv <= {iv[119:0], cipher_input_reg};
		end else if (state == acp_pkg::ACP_S_RUN && cif.done && chain) begin
			iv <= decrypt ? in_blk : cif.dout;
		end else if (blk_end && stream) begin
			if (mode == `ACP_MODE_CFB) begin
				iv <= decrypt ? in_blk : out_blk;
			end else if (mode == `ACP_MODE_OFB) begin
				iv <= ks;
			end else begin
				iv[31:0] <= 32'(iv[31:0] + 32'h1); // Counter wraps in 32 bits
			end
		end
	end

	// Keystream block for the stream modes
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ks <= 128'h0;
		end else if (state == acp_pkg::ACP_S_KS && cif.done) begin
			ks <= cif.dout;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data buffers

	// Stream bytes are combined with keystream on arrival
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 16; i++) begin
				in_arr[i]  <= 8'h00;
				out_arr[i] <= 8'h00;
			end
		end else if (wr_ok && state == acp_pkg::ACP_S_IN) begin
			in_arr[icnt] <= cipher_input_reg;
			if (stream) begin
				out_arr[icnt] <= cipher_input_reg ^ byte_of(ks, icnt);
			end
		end else if (state == acp_pkg::ACP_S_RUN && cif.done) begin
			for (int i = 0; i < 16; i++) begin
				out_arr[i] <= byte_of(cif.dout ^ ((chain && decrypt) ? iv : 128'h0), 4'(i));
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core control

	// Core is pulsed on entry to a state that needs it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			go    <= 1'b0;
			abort <= 1'b0;
		end else begin
			go    <= (next_state != state) & ((next_state == acp_pkg::ACP_S_PREP)
				| (next_state == acp_pkg::ACP_S_KS) | (next_state == acp_pkg::ACP_S_RUN));
			abort <= ld_cmd;
		end
	end

	assign cif.go    = go;
	assign cif.abort = abort;
	assign cif.key   = key;

	// Stream modes always run the forward cipher on the IV
	always_comb begin
		if (state == acp_pkg::ACP_S_PREP) begin
			cif.op = acp_pkg::ACP_OP_PREP;
		end else if (stream || !decrypt) begin
			cif.op = acp_pkg::ACP_OP_ENC;
		end else begin
			cif.op = acp_pkg::ACP_OP_DEC;
		end
	end

	// CBC encryption folds the IV in before the cipher
	assign cif.din = stream ? iv : ((chain && !decrypt) ? (in_blk ^ iv) : in_blk);

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Requests drop for one cycle after each transfer so one edge means one byte
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			input_dma_request  <= 1'b0;
			output_dma_request <= 1'b0;
		end else begin
			input_dma_request  <= ~wr_ok & ((next_state == acp_pkg::ACP_S_KEY)
				| (next_state == acp_pkg::ACP_S_IV) | (next_state == acp_pkg::ACP_S_IN));
			output_dma_request <= ~rd_ok & (state == acp_pkg::ACP_S_OUT)
				& (next_state == acp_pkg::ACP_S_OUT);
		end
	end

	// Output byte follows the read pointer
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cipher_output_reg <= 8'h00;
		end else begin
			cipher_output_reg <= out_arr[rd_ok ? 4'(ocnt + 4'h1) : ocnt];
		end
	end

	// Block interrupt once the last result byte is read
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			block_done_irq <= 1'b0;
		end else begin
			block_done_irq <= blk_end;
		end
	end

	// Status byte; ready bit is low while any operation is in flight
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cipher_ctrl_status_reg <= 8'h00;
		end else begin
			cipher_ctrl_status_reg <= 8'h00;
			cipher_ctrl_status_reg[`ACP_CMD_LSB +: 2]  <= cmd;
			cipher_ctrl_status_reg[`ACP_RDY_BIT]       <= (state == acp_pkg::ACP_S_IDLE);
			cipher_ctrl_status_reg[`ACP_MODE_LSB +: 3] <= mode;
		end
	end

endmodule
`default_nettype wire

// File: acp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "acp_map.svh"
module acp_host_model (
	input  wire logic       mclk,
	input  wire logic [7:0] cipher_ctrl_status_reg,
	input  wire logic [7:0] cipher_output_reg,
	input  wire logic       input_dma_request,
	input  wire logic       output_dma_request,
	output var  logic       ctrl_wr,
	output var  logic [7:0] ctrl_wdata,
	output var  logic       din_wr,
	output var  logic [7:0] cipher_input_reg,
	output var  logic       dout_rd
);
	int tmo = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Idle levels; released lines show the inverse
	initial begin
		ctrl_wr = 1'b0;
		ctrl_wdata = 8'h00;
		din_wr = 1'b0;
		cipher_input_reg = 8'h00;
		dout_rd = 1'b0;
	end

	// Bounded wait on a request line or on the ready flag
	task automatic wait_for(input int sel);
		int n;
		n = 0;
		while (!(sel == 0 ? input_dma_request : sel == 1 ? output_dma_request
			: cipher_ctrl_status_reg[3]) && n < 40) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 40) tmo++;
	endtask

	// CPU write of the control byte
	task automatic ctrl(input logic [7:0] b);
		@(negedge mclk);
		ctrl_wdata = b;
		ctrl_wr = 1'b1;
		@(negedge mclk);
		ctrl_wr = 1'b0;
		ctrl_wdata = ~b;
	endtask

	// Input channel: one byte per request, one idle cycle so a lagging request is not reused
	task automatic put(input logic [7:0] b);
		wait_for(0);
		din_wr = 1'b1;
		cipher_input_reg = b;
		@(negedge mclk);
		din_wr = 1'b0;
		cipher_input_reg = ~b;
		@(negedge mclk);
	endtask

	// Output channel: data is taken while the request is up
	task automatic get(output logic [7:0] b);
		wait_for(1);
		b = cipher_output_reg;
		dout_rd = 1'b1;
		@(negedge mclk);
		dout_rd = 1'b0;
		@(negedge mclk);
	endtask

	// Key or IV load: command first, then 16 bytes, MSB first
	task automatic load(input logic [7:0] cmd, input logic [127:0] v);
		ctrl(cmd);
		for (int i = 0; i < 16; i++) put(v[127 - 8 * i -: 8]);
		wait_for(2);
	endtask

	// One block; stream modes go word by word, callers pass zero-padded data
	task automatic block(input logic [7:0] cmd, input logic [127:0] d,
		output logic [127:0] r);
		int         n;
		logic [7:0] b;
		n = (cmd[6:4] inside {`ACP_MODE_CFB, `ACP_MODE_OFB, `ACP_MODE_CTR}) ? 4 : 16;
		ctrl(cmd);
		for (int g = 0; g < 16; g += n) begin
			for (int i = g; i < g + n; i++) put(d[127 - 8 * i -: 8]);
			for (int i = g; i < g + n; i++) begin
				get(b);
				r[127 - 8 * i -: 8] = b;
			end
		end
		wait_for(2);
	endtask
endmodule
`default_nettype wire

// File: acp_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module acp_top_chk (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       ctrl_wr,
	input  wire logic [7:0] ctrl_wdata,
	input  wire logic [7:0] cipher_ctrl_status_reg,
	input  wire logic       din_wr,
	input  wire logic [7:0] cipher_input_reg,
	input  wire logic       dout_rd,
	input  wire logic [7:0] cipher_output_reg,
	input  wire logic       input_dma_request,
	input  wire logic       output_dma_request,
	input  wire logic       block_done_irq
);
	logic       run_start;
	logic       load_start;
	logic [4:0] rd_cnt;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////////
	// Command decode; key and IV loads are the only commands with cmd bit 1 set
	assign run_start  = ctrl_wr && ctrl_wdata[0] && !ctrl_wdata[2];
	assign load_start = ctrl_wr && ctrl_wdata[0] && ctrl_wdata[2];

	// Result bytes read since the last completion or abort
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_cnt <= 5'h00;
		end else if (block_done_irq || load_start) begin
			rd_cnt <= 5'h00;
		end else if (dout_rd && output_dma_request) begin
			rd_cnt <= rd_cnt + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	reset_quiet_a: assert property ($rose(rst_n) |-> !input_dma_request
		&& !output_dma_request && !block_done_irq) else $error("outputs not idle after reset");
	status_pad_a: assert property (cipher_ctrl_status_reg[7] == 1'b0
		&& cipher_ctrl_status_reg[0] == 1'b0) else $error("status unused bits set");
	one_side_a: assert property (!(input_dma_request && output_dma_request))
		else $error("both request lines high");
	start_trig_a: assert property (run_start && cipher_ctrl_status_reg[3]
		|-> ##[1:20] input_dma_request) else $error("start gave no input request");
	busy_flag_a: assert property ((load_start || (run_start && cipher_ctrl_status_reg[3]))
		|-> ##[2:3] !cipher_ctrl_status_reg[3]) else $error("busy not shown");
	refuse_mode_a: assert property (run_start && !cipher_ctrl_status_reg[3]
		##1 !cipher_ctrl_status_reg[3] |=> cipher_ctrl_status_reg[6:4]
		== $past(cipher_ctrl_status_reg[6:4])) else $error("busy start changed mode");
	load_abort_a: assert property (load_start |-> ##[1:2]
		(input_dma_request && !output_dma_request)) else $error("load did not abort");
	out_hold_a: assert property (output_dma_request && !dout_rd && !load_start
		|=> output_dma_request && $stable(cipher_output_reg)) else $error("output byte lost");
	in_step_a: assert property (din_wr && input_dma_request |-> ##[1:2]
		!input_dma_request) else $error("input request held after write");
	out_step_a: assert property (dout_rd && output_dma_request |-> ##[1:2]
		!output_dma_request) else $error("output request held after read");
	irq_count_a: assert property (block_done_irq |-> rd_cnt == 5'h10)
		else $error("completion without 16 reads");
	irq_pulse_a: assert property (block_done_irq |=> !block_done_irq
		##[0:2] cipher_ctrl_status_reg[3]) else $error("completion pulse or ready wrong");

	// Main scenarios reached
	cover property (block_done_irq);
	cover property (run_start && input_dma_request);
	cover property (load_start && !cipher_ctrl_status_reg[3]);
endmodule

bind acp_top acp_top_chk chk_i (.mclk(mclk), .rst_n(rst_n), .ctrl_wr(ctrl_wr),
	.ctrl_wdata(ctrl_wdata), .cipher_ctrl_status_reg(cipher_ctrl_status_reg),
	.din_wr(din_wr), .cipher_input_reg(cipher_input_reg), .dout_rd(dout_rd),
	.cipher_output_reg(cipher_output_reg), .input_dma_request(input_dma_request),
	.output_dma_request(output_dma_request), .block_done_irq(block_done_irq));
`default_nettype wire

// File: aes_block_coprocessor_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "acp_map.svh"
module aes_block_coprocessor_bench;
	// Published cipher test vectors
	localparam logic [127:0] KEY_A = 128'h000102030405060708090A0B0C0D0E0F;
	localparam logic [127:0] PLAIN = 128'h00112233445566778899AABBCCDDEEFF;
	localparam logic [127:0] CIPH  = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
	localparam logic [127:0] ZCIPH = 128'h66E94BD4EF8A2C3B884CFA59CA342B2E;

	logic         mclk;
	logic         rst_n;
	logic         ctrl_wr;
	logic [7:0]   ctrl_wdata;
	logic [7:0]   cipher_ctrl_status_reg;
	logic         din_wr;
	logic [7:0]   cipher_input_reg;
	logic         dout_rd;
	logic [7:0]   cipher_output_reg;
	logic         input_dma_request;
	logic         output_dma_request;
	logic         block_done_irq;
	int           err_total = 0;
	int           num_checks = 0;
	int           irq_n = 0;
	int           base;
	logic [2:0]   md;
	logic         strm;
	logic [127:0] got;

	acp_top dut (.mclk(mclk), .rst_n(rst_n), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
		.cipher_ctrl_status_reg(cipher_ctrl_status_reg), .din_wr(din_wr),
		.cipher_input_reg(cipher_input_reg), .dout_rd(dout_rd),
		.cipher_output_reg(cipher_output_reg), .input_dma_request(input_dma_request),
		.output_dma_request(output_dma_request), .block_done_irq(block_done_irq));

	acp_host_model mdl (.mclk(mclk), .cipher_ctrl_status_reg(cipher_ctrl_status_reg),
		.cipher_output_reg(cipher_output_reg), .input_dma_request(input_dma_request),
		.output_dma_request(output_dma_request), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
		.din_wr(din_wr), .cipher_input_reg(cipher_input_reg), .dout_rd(dout_rd));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and completion-pulse counter
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (block_done_irq === 1'b1) irq_n++;
	end

	function automatic logic [7:0] cw(input logic [1:0] cmd, input logic [2:0] m);
		return {1'b0, m, 1'b0, cmd, 1'b1};
	endfunction

	task automatic chk(input logic [127:0] g, input logic [127:0] e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic stop_test();
		err_total += mdl.tmo;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// A hung wait ends the run when the test that hit it finishes
	task automatic note(input string s);
		$display("test %s finished", s);
		if (mdl.tmo != 0) stop_test();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_n = 1'b0;
		repeat (12) @(negedge mclk);
		rst_n = 1'b1;
		@(negedge mclk);
		chk(128'(cipher_ctrl_status_reg), 128'h08);
		chk(128'({input_dma_request, output_dma_request, block_done_irq}), 128'h0);
		note("reset");

		// Every mode: block modes on the plaintext with zero IV, stream modes on zeros
		mdl.load(cw(`ACP_CMD_LDKEY, 3'h0), KEY_A);
		for (int m = 0; m < 6; m++) begin
			md = m[2:0];
			strm = md inside {`ACP_MODE_CFB, `ACP_MODE_OFB, `ACP_MODE_CTR};
			mdl.load(cw(`ACP_CMD_LDIV, md), strm ? PLAIN : 128'h0);
			base = irq_n;
			mdl.block(cw(`ACP_CMD_ENC, md), strm ? 128'h0 : PLAIN, got);
			chk(got, CIPH);
			chk(128'(irq_n - base), 128'h1);
		end
		note("modes");

		// Chained MAC: first block in MAC mode, last block in CBC gives the tag
		mdl.load(cw(`ACP_CMD_LDIV, `ACP_MODE_MAC), 128'h0);
		mdl.block(cw(`ACP_CMD_ENC, `ACP_MODE_MAC), PLAIN, got);
		chk(got, CIPH);
		mdl.block(cw(`ACP_CMD_ENC, `ACP_MODE_CBC), CIPH ^ PLAIN, got);
		chk(got, CIPH);
		note("chain");

		// Start while busy is ignored; an IV load mid-block aborts it
		mdl.ctrl(cw(`ACP_CMD_ENC, `ACP_MODE_ECB));
		for (int i = 0; i < 3; i++) mdl.put(8'h5A);
		mdl.ctrl(cw(`ACP_CMD_DEC, `ACP_MODE_CBC));
		repeat (3) @(negedge mclk);
		chk(128'(cipher_ctrl_status_reg), 128'(8'h40));
		mdl.load(cw(`ACP_CMD_LDIV, `ACP_MODE_ECB), 128'h0);
		mdl.block(cw(`ACP_CMD_ENC, `ACP_MODE_ECB), PLAIN, got);
		chk(got, CIPH);
		mdl.block(cw(`ACP_CMD_DEC, `ACP_MODE_ECB), CIPH, got);
		chk(got, PLAIN);
		note("busy_abort");

		// Reset in mid-block clears the key to zero
		mdl.ctrl(cw(`ACP_CMD_ENC, `ACP_MODE_ECB));
		mdl.put(8'hA5);
		rst_n = 1'b0;
		repeat (3) @(negedge mclk);
		rst_n = 1'b1;
		@(negedge mclk);
		chk(128'(cipher_ctrl_status_reg), 128'h08);
		mdl.load(cw(`ACP_CMD_LDIV, `ACP_MODE_ECB), 128'h0);
		mdl.block(cw(`ACP_CMD_ENC, `ACP_MODE_ECB), 128'h0, got);
		chk(got, ZCIPH);
		note("mid_reset");
		stop_test();
	end
endmodule
`default_nettype wire
